// *** logic/dsac_pkg.sv ***
// Constants shared by the delta-sigma converter control block.
package dsac_pkg;
   localparam logic [7:0] ADDR_CONN = 8'h00;
   localparam logic [7:0] ADDR_CHAN = 8'h04;
   localparam logic [7:0] ADDR_LNA = 8'h08;
   localparam logic [7:0] ADDR_RES_LO = 8'h0C;
   localparam logic [7:0] ADDR_RES_MID = 8'h10;
   localparam logic [7:0] ADDR_RES_HI = 8'h14;
   localparam logic [7:0] ADDR_FRATE = 8'h18;
   localparam logic [7:0] ADDR_CCTRL = 8'h1C;
   localparam logic [7:0] ADDR_PRESC = 8'h20;
   localparam logic [3:0] IDX_CONN = 4'h0;
   localparam logic [3:0] IDX_CHAN = 4'h1;
   localparam logic [3:0] IDX_LNA = 4'h2;
   localparam logic [3:0] IDX_RES_LO = 4'h3;
   localparam logic [3:0] IDX_RES_MID = 4'h4;
   localparam logic [3:0] IDX_RES_HI = 4'h5;
   localparam logic [3:0] IDX_FRATE = 4'h6;
   localparam logic [3:0] IDX_CCTRL = 4'h7;
   localparam logic [3:0] IDX_PRESC = 4'h8;
   localparam logic [3:0] IDX_NONE = 4'hF;
   localparam logic [7:0] MASK_CONN = 8'hE0;
   localparam logic [7:0] MASK_CHAN = 8'hFF;
   localparam logic [7:0] MASK_LNA = 8'h87;
   localparam logic [7:0] MASK_FRATE = 8'hFF;
   localparam logic [7:0] MASK_CCTRL = 8'h3C;
   localparam logic [7:0] MASK_PRESC = 8'h1F;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [23:0] RST_RESULT = 24'h00_0000;
   localparam int CONN_JOIN_BIT = 7;
   localparam int CONN_ROUTE_LSB = 5;
   localparam int CHAN_NEG_LSB = 4;
   localparam int CHAN_POS_LSB = 0;
   localparam int LNA_EN_BIT = 7;
   localparam int LNA_POS_BIT = 2;
   localparam int LNA_SW1_BIT = 1;
   localparam int LNA_SW0_BIT = 0;
   localparam int FR_ORDER_BIT = 7;
   localparam int FR_NSEL_LSB = 4;
   localparam int FR_OSR_LSB = 0;
   localparam int CC_HOLD_BIT = 5;
   localparam int CC_EOC_BIT = 4;
   localparam int CC_SRST_BIT = 3;
   localparam int CC_ON_BIT = 2;
   localparam logic [4:0] PRESC_BYPASS = 5'h1F;
   localparam logic [4:0] NDIV_30 = 5'h1E;
   localparam logic [4:0] NDIV_12 = 5'h0C;
   localparam logic [3:0] OSR_CODE_MAX = 4'h8;
   localparam int OSR_MAX_LOG2_DEF = 15;
   localparam int FRAME_W = 17;
endpackage

// *** logic/dsac_clkgen.sv ***
// Master clock prescaler and modulator divider, as clock-enable ticks.
`timescale 1ns/1ps
`default_nettype none
module dsac_clkgen (
   // Clock, reset and enable.
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // Settings.
   input wire logic [4:0] presc_in,
   input wire logic [1:0] nsel_in,
   // Ticks.
   output logic mclk_tick_out,
   output logic mod_tick_out
);
   import dsac_pkg::*;

   typedef struct packed {
      logic [5:0] pcnt;
      logic [4:0] ncnt;
      logic mclk;
      logic modt;
   } dsac_clk_t;

   dsac_clk_t s;
   dsac_clk_t next_s;
   logic hit;
   logic [5:0] plim;
   logic [4:0] nlim;

   always_comb begin
      next_s = s;
      // Period 2*(code+1) cycles is a terminal count of {code,1}.
      plim = {presc_in, 1'b1};
      hit = (presc_in == PRESC_BYPASS) || (s.pcnt >= plim);
      nlim = nsel_in[1] ? (NDIV_12 - 5'h01) : (NDIV_30 - 5'h01);
      next_s.pcnt = hit ? 6'h00 : s.pcnt + 6'h01;
      next_s.mclk = hit;
      next_s.modt = 1'b0;
      if (hit) begin
         if (s.ncnt >= nlim) begin
            next_s.ncnt = 5'h00;
            next_s.modt = 1'b1;
         end else begin
            next_s.ncnt = s.ncnt + 5'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s <= '0;
      end else if (ce_in) begin
         s <= next_s;
      end
   end

   assign mclk_tick_out = s.mclk;
   assign mod_tick_out = s.modt;

   property p_bypass_every_cycle;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
         (ce_in && presc_in == PRESC_BYPASS) |=> mclk_tick_out;
   endproperty
   a_bypass_every_cycle: assert property (p_bypass_every_cycle)
      else $error("master tick missing in bypass");

   property p_mod_on_master;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
         mod_tick_out |-> mclk_tick_out;
   endproperty
   a_mod_on_master: assert property (p_mod_on_master)
      else $error("modulator tick without master tick");
endmodule
`default_nettype wire

// *** logic/dsac_decim.sv ***
// Frame counter and accumulating decimator for the modulator bitstream.
`timescale 1ns/1ps
`default_nettype none
module dsac_decim #(
   parameter int FRAME_W = 17
) (
   // Clock, reset and enable.
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // Control.
   input wire logic clr_in,
   input wire logic tick_in,
   input wire logic bit_in,
   input wire logic [FRAME_W-1:0] frame_last_in,
   // Result.
   output logic done_out,
   output logic [23:0] result_out
);
   typedef struct packed {
      logic [FRAME_W-1:0] cnt;
      logic [23:0] acc;
      logic [23:0] res;
      logic done;
   } dsac_dec_t;

   dsac_dec_t s;
   dsac_dec_t next_s;
   logic [23:0] sum;

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      sum = bit_in ? s.acc + 24'h00_0001 : s.acc - 24'h00_0001;
      if (clr_in) begin
         // Held clear keeps the frame from ever starting.
         next_s.cnt = '0;
         next_s.acc = '0;
      end else if (tick_in) begin
         if (s.cnt >= frame_last_in) begin
            next_s.cnt = '0;
            next_s.acc = '0;
            next_s.res = sum;
            next_s.done = 1'b1;
         end else begin
            next_s.cnt = s.cnt + 1'b1;
            next_s.acc = sum;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s <= '0;
      end else if (ce_in) begin
         s <= next_s;
      end
   end

   assign done_out = s.done;
   assign result_out = s.res;
endmodule
`default_nettype wire

// *** logic/dsac_top.sv ***
// Delta-sigma converter control: APB registers, rates, results, flags.
`timescale 1ns/1ps
`default_nettype none
module dsac_top #(
   parameter int OSR_MAX_LOG2 = dsac_pkg::OSR_MAX_LOG2_DEF
) (
   // Clock, reset and enable.
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic ce_in,
   // APB slave.
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Modulator bitstream from the analog front end.
   input wire logic mod_bit_in,
   // Input routing controls.
   output logic input_ends_join_out,
   output logic [1:0] input_route_cfg_out,
   output logic [3:0] neg_input_sel_out,
   output logic [3:0] pos_input_sel_out,
   // Low-noise amplifier controls.
   output logic lownoise_amp_en_out,
   output logic lownoise_amp_pos_sel_out,
   output logic lownoise_switch_1_out,
   output logic lownoise_switch_0_out,
   // Converter controls and events.
   output logic converter_on_out,
   output logic filter_soft_reset_out,
   output logic mod_tick_out,
   output logic conv_irq_out
);
   import dsac_pkg::*;

   if (OSR_MAX_LOG2 < 8 || OSR_MAX_LOG2 > 15) begin : g_bad_osr
      $error("OSR_MAX_LOG2 must lie between 8 and 15");
   end

   typedef struct packed {
      logic [7:0] conn;
      logic [7:0] chan;
      logic [7:0] lna;
      logic [7:0] frate;
      logic [7:0] cctrl;
      logic [7:0] presc;
      logic [23:0] result;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } dsac_state_t;

   dsac_state_t s;
   dsac_state_t next_s;
   logic [1:0] rst_sync;
   logic rst_n;
   logic [1:0] bit_sync;
   logic mod_tick;
   logic dec_done;
   logic [23:0] dec_result;
   logic dec_clr;
   logic [FRAME_W-1:0] frame_last;
   logic [3:0] idx;
   logic setup;
   logic access;
   logic wr;
   logic accept;
   logic hold;

   // Address decode shared by the read and the write path.
   function automatic logic [3:0] reg_index(input logic [7:0] a);
      logic [3:0] r;
      r = IDX_NONE;
      if (a == ADDR_CONN) begin
         r = IDX_CONN;
      end else if (a == ADDR_CHAN) begin
         r = IDX_CHAN;
      end else if (a == ADDR_LNA) begin
         r = IDX_LNA;
      end else if (a == ADDR_RES_LO) begin
         r = IDX_RES_LO;
      end else if (a == ADDR_RES_MID) begin
         r = IDX_RES_MID;
      end else if (a == ADDR_RES_HI) begin
         r = IDX_RES_HI;
      end else if (a == ADDR_FRATE) begin
         r = IDX_FRATE;
      end else if (a == ADDR_CCTRL) begin
         r = IDX_CCTRL;
      end else if (a == ADDR_PRESC) begin
         r = IDX_PRESC;
      end
      return r;
   endfunction

   // Frame length in modulator ticks, less one.
   function automatic logic [FRAME_W-1:0] frame_len_m1(input logic [3:0] code,
                                                       input logic order2);
      logic [3:0] c;
      logic [4:0] sh;
      logic [FRAME_W:0] len;
      c = (code > OSR_CODE_MAX) ? OSR_CODE_MAX : code;
      sh = 5'(OSR_MAX_LOG2) - {1'b0, c};
      len = (FRAME_W + 1)'(1) << sh;
      if (order2) begin
         len = len << 1;
      end
      return FRAME_W'(len - 1'b1);
   endfunction

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         bit_sync <= 2'b00;
      end else if (ce_in) begin
         bit_sync <= {bit_sync[0], mod_bit_in};
      end
   end

   dsac_clkgen u_clkgen (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n),
      .ce_in(ce_in),
      .presc_in(s.presc[4:0]),
      .nsel_in(s.frate[FR_NSEL_LSB +: 2]),
      .mclk_tick_out(),
      .mod_tick_out(mod_tick)
   );

   assign frame_last = frame_len_m1(s.frate[FR_OSR_LSB +: 4], s.frate[FR_ORDER_BIT]);
   assign dec_clr = s.cctrl[CC_SRST_BIT] || !s.cctrl[CC_ON_BIT];

   dsac_decim #(
      .FRAME_W(FRAME_W)
   ) u_decim (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n),
      .ce_in(ce_in),
      .clr_in(dec_clr),
      .tick_in(mod_tick),
      .bit_in(bit_sync[1]),
      .frame_last_in(frame_last),
      .done_out(dec_done),
      .result_out(dec_result)
   );

   assign idx = reg_index(paddr_in);
   assign setup = psel_in && !penable_in;
   assign access = psel_in && penable_in && s.pready;
   assign wr = access && pwrite_in;
   assign hold = s.cctrl[CC_HOLD_BIT];
   assign accept = dec_done && !hold;

   always_comb begin
      next_s = s;
      next_s.irq = 1'b0;
      next_s.pready = setup;
      if (setup) begin
         next_s.pslverr = (idx == IDX_NONE);
         case (idx)
            IDX_CONN: next_s.prdata = {24'h00_0000, s.conn};
            IDX_CHAN: next_s.prdata = {24'h00_0000, s.chan};
            IDX_LNA: next_s.prdata = {24'h00_0000, s.lna};
            IDX_RES_LO: next_s.prdata = {24'h00_0000, s.result[7:0]};
            IDX_RES_MID: next_s.prdata = {24'h00_0000, s.result[15:8]};
            IDX_RES_HI: next_s.prdata = {24'h00_0000, s.result[23:16]};
            IDX_FRATE: next_s.prdata = {24'h00_0000, s.frate};
            IDX_CCTRL: next_s.prdata = {24'h00_0000, s.cctrl};
            IDX_PRESC: next_s.prdata = {24'h00_0000, s.presc};
            default: next_s.prdata = 32'h0000_0000;
         endcase
      end else if (access) begin
         next_s.pslverr = 1'b0;
      end
      if (wr) begin
         // Masks keep unimplemented bits at zero.
         if (idx == IDX_CONN) begin
            next_s.conn = pwdata_in[7:0] & MASK_CONN;
         end else if (idx == IDX_CHAN) begin
            next_s.chan = pwdata_in[7:0] & MASK_CHAN;
         end else if (idx == IDX_LNA) begin
            next_s.lna = pwdata_in[7:0] & MASK_LNA;
         end else if (idx == IDX_FRATE) begin
            next_s.frate = pwdata_in[7:0] & MASK_FRATE;
         end else if (idx == IDX_CCTRL) begin
            next_s.cctrl = pwdata_in[7:0] & MASK_CCTRL;
            // Writing one leaves the end flag as it is.
            next_s.cctrl[CC_EOC_BIT] = s.cctrl[CC_EOC_BIT] && pwdata_in[CC_EOC_BIT];
         end else if (idx == IDX_PRESC) begin
            next_s.presc = pwdata_in[7:0] & MASK_PRESC;
         end
      end
      if (accept) begin
         next_s.result = dec_result;
         next_s.cctrl[CC_EOC_BIT] = 1'b1;
         next_s.irq = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         s.conn <= RST_REG;
         s.chan <= RST_REG;
         s.lna <= RST_REG;
         s.frate <= RST_REG;
         s.cctrl <= RST_REG;
         s.presc <= RST_REG;
         s.result <= RST_RESULT;
         s.prdata <= 32'h0000_0000;
         s.pready <= 1'b0;
         s.pslverr <= 1'b0;
         s.irq <= 1'b0;
      end else if (ce_in) begin
         s <= next_s;
      end
   end

   assign prdata_out = s.prdata;
   assign pready_out = s.pready;
   assign pslverr_out = s.pslverr;
   assign input_ends_join_out = s.conn[CONN_JOIN_BIT];
   assign input_route_cfg_out = s.conn[CONN_ROUTE_LSB +: 2];
   assign neg_input_sel_out = s.chan[CHAN_NEG_LSB +: 4];
   assign pos_input_sel_out = s.chan[CHAN_POS_LSB +: 4];
   assign lownoise_amp_en_out = s.lna[LNA_EN_BIT];
   assign lownoise_amp_pos_sel_out = s.lna[LNA_POS_BIT];
   assign lownoise_switch_1_out = s.lna[LNA_SW1_BIT];
   assign lownoise_switch_0_out = s.lna[LNA_SW0_BIT];
   assign converter_on_out = s.cctrl[CC_ON_BIT];
   assign filter_soft_reset_out = s.cctrl[CC_SRST_BIT];
   assign mod_tick_out = mod_tick;
   assign conv_irq_out = s.irq;

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n);

   property p_result_with_flag;
      (ce_in && dec_done && !hold) |=> (s.cctrl[CC_EOC_BIT] && s.result == $past(dec_result));
   endproperty
   a_result_with_flag: assert property (p_result_with_flag)
      else $error("result and end flag not written together");

   property p_hold_keeps_result;
      hold |=> (s.result == $past(s.result));
   endproperty
   a_hold_keeps_result: assert property (p_hold_keeps_result)
      else $error("result changed while held");

   property p_hold_keeps_flag;
      (hold && !(wr && idx == IDX_CCTRL)) |=> $stable(s.cctrl[CC_EOC_BIT]);
   endproperty
   a_hold_keeps_flag: assert property (p_hold_keeps_flag)
      else $error("end flag changed while held");

   property p_irq_cause;
      $rose(conv_irq_out) |-> $past(dec_done && !hold && ce_in);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt without accepted conversion");

   property p_flag_clear_by_sw;
      $fell(s.cctrl[CC_EOC_BIT]) |-> $past(wr && idx == IDX_CCTRL && !pwdata_in[CC_EOC_BIT]);
   endproperty
   a_flag_clear_by_sw: assert property (p_flag_clear_by_sw)
      else $error("end flag cleared without software write");

   property p_srst_no_result;
      (s.cctrl[CC_SRST_BIT] && ce_in) ##1 s.cctrl[CC_SRST_BIT] |-> !dec_done;
   endproperty
   a_srst_no_result: assert property (p_srst_no_result)
      else $error("conversion ended under soft reset");

   property p_off_no_result;
      (!s.cctrl[CC_ON_BIT] && ce_in) ##1 !s.cctrl[CC_ON_BIT] |-> !dec_done;
   endproperty
   a_off_no_result: assert property (p_off_no_result)
      else $error("conversion ended while converter off");

   property p_reserved_zero;
      (s.cctrl[7:6] == 2'b00 && s.cctrl[1:0] == 2'b00 && s.conn[4:0] == 5'h00
       && s.presc[7:5] == 3'h0 && s.lna[6:3] == 4'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("unimplemented bit set");

   property p_answer_next;
      (setup && ce_in) |=> pready_out;
   endproperty
   a_answer_next: assert property (p_answer_next)
      else $error("APB answer not one cycle after setup");

   property p_read_upper_zero;
      pready_out |-> (prdata_out[31:8] == 24'h00_0000);
   endproperty
   a_read_upper_zero: assert property (p_read_upper_zero)
      else $error("read data above the byte not zero");

   property p_unmapped_refused;
      (ce_in && setup && idx == IDX_NONE) |=> (pslverr_out && prdata_out == 32'h0000_0000);
   endproperty
   a_unmapped_refused: assert property (p_unmapped_refused)
      else $error("unmapped address not refused");

   property p_ro_result;
      (ce_in && wr && !accept && (idx == IDX_RES_LO || idx == IDX_RES_MID
                                  || idx == IDX_RES_HI)) |=> $stable(s.result);
   endproperty
   a_ro_result: assert property (p_ro_result)
      else $error("result changed by a software write");

   property p_chan_write;
      (ce_in && wr && idx == IDX_CHAN)
         |=> ({neg_input_sel_out, pos_input_sel_out} == $past(pwdata_in[7:0]));
   endproperty
   a_chan_write: assert property (p_chan_write)
      else $error("input selectors differ from the written codes");

   property p_irq_follows_accept;
      (ce_in && accept) |=> conv_irq_out;
   endproperty
   a_irq_follows_accept: assert property (p_irq_follows_accept)
      else $error("accepted conversion without interrupt pulse");

   property p_irq_one_cycle;
      (ce_in && conv_irq_out) |=> !conv_irq_out;
   endproperty
   a_irq_one_cycle: assert property (p_irq_one_cycle)
      else $error("interrupt pulse longer than one cycle");

   c_flag_set: cover property ($rose(s.cctrl[CC_EOC_BIT]));
   c_held_discard: cover property (hold && dec_done);
   c_soft_reset: cover property ($fell(s.cctrl[CC_SRST_BIT]));
   c_bad_addr: cover property (pready_out && pslverr_out);
endmodule
`default_nettype wire

// *** verification/tb_delta_sigma_adc_control.sv ***
// Self-checking testbench for the delta-sigma converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb_delta_sigma_adc_control;
   import dsac_pkg::*;
   localparam int OSR_LOG2 = 8;
   logic clk_sys_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic mod_bit = 1'b1;
   logic ce = 1'b1;
   logic [31:0] prdata;
   logic pready, pslverr, join_o, on_o, srst_o, tick_o, irq_o;
   logic lna_en, lna_pos, lna_sw1, lna_sw0;
   logic [1:0] route_o;
   logic [3:0] neg_o, pos_o;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   int irq_cnt = 0;
   int irq_last = 0;
   int irq_gap = 0;
   int tick_cnt = 0;
   int tick_last = 0;
   int tick_gap = 0;

   dsac_top #(.OSR_MAX_LOG2(OSR_LOG2)) dut (
      .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .ce_in(ce),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .mod_bit_in(mod_bit), .input_ends_join_out(join_o), .input_route_cfg_out(route_o),
      .neg_input_sel_out(neg_o), .pos_input_sel_out(pos_o), .lownoise_amp_en_out(lna_en),
      .lownoise_amp_pos_sel_out(lna_pos), .lownoise_switch_1_out(lna_sw1),
      .lownoise_switch_0_out(lna_sw0), .converter_on_out(on_o),
      .filter_soft_reset_out(srst_o), .mod_tick_out(tick_o), .conv_irq_out(irq_o)
   );

   initial begin
      forever #20 clk_sys_in = ~clk_sys_in;
   end

   // Event counters record the spacing of the last two pulses in system cycles.
   always @(posedge clk_sys_in) begin
      cyc++;
      if (irq_o === 1'b1) begin
         irq_cnt++;
         irq_gap = cyc - irq_last;
         irq_last = cyc;
      end
      if (tick_o === 1'b1) begin
         tick_cnt++;
         tick_gap = cyc - tick_last;
         tick_last = cyc;
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int t;
      t = 0;
      @(posedge clk_sys_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         t++;
      end while (pready !== 1'b1 && t < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (t >= 50) chk("pready_wait", 32'h0000_0000, 32'h0000_0001);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, {24'h00_0000, d}, q, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
   endtask

   task automatic rd_res(output logic [31:0] r);
      logic [31:0] lo, mid, hi;
      rd(ADDR_RES_LO, lo);
      rd(ADDR_RES_MID, mid);
      rd(ADDR_RES_HI, hi);
      r = {8'h00, hi[7:0], mid[7:0], lo[7:0]};
   endtask

   task automatic wait_ev(input bit irq, input int n);
      int c0, t;
      c0 = irq ? irq_cnt : tick_cnt;
      t = 0;
      while (((irq ? irq_cnt : tick_cnt) < c0 + n) && t < 20000) begin
         @(posedge clk_sys_in);
         t++;
      end
      if (t >= 20000) chk("event_wait", 32'h0000_0000, 32'h0000_0001);
   endtask

   task automatic t_regs;
      logic [7:0] a[6] = '{ADDR_CONN, ADDR_CHAN, ADDR_LNA, ADDR_FRATE, ADDR_CCTRL, ADDR_PRESC};
      logic [7:0] w[6] = '{8'hFF, 8'hA5, 8'hFF, 8'hFF, 8'hC3, 8'hFF};
      logic [7:0] x[6] = '{8'hE0, 8'hA5, 8'h87, 8'hFF, 8'h00, 8'h1F};
      logic [31:0] q;
      logic e;
      for (int i = 0; i < 6; i++) begin
         rd(a[i], q);
         chk("reg_reset", q, 32'h0000_0000);
         wr(a[i], w[i]);
         rd(a[i], q);
         chk("reg_readback", q, {24'h00_0000, x[i]});
      end
      chk("route_outputs", {join_o, route_o, lna_en, lna_pos, lna_sw1, lna_sw0},
          32'h0000_007F);
      chk("conv_outputs", {on_o, srst_o}, 32'h0000_0000);
      apb(1'b1, 8'h24, 32'h0000_00FF, q, e);
      chk("unmapped_err", e, 32'h0000_0001);
      apb(1'b0, 8'h24, 32'h0000_0000, q, e);
      chk("unmapped_rd", {e, q[30:0]}, 32'h8000_0000);
      for (int c = 0; c < 16; c++) begin
         wr(ADDR_CHAN, {c[3:0], ~c[3:0]});
         @(posedge clk_sys_in);
         chk("input_sel", {neg_o, pos_o}, {24'h00_0000, c[3:0], ~c[3:0]});
      end
      wr(ADDR_CHAN, 8'h80);
      @(posedge clk_sys_in);
      chk("single_ended", {neg_o, pos_o}, 32'h0000_0080);
      wr(ADDR_CHAN, 8'hAA);
      @(posedge clk_sys_in);
      chk("temp_pair", {neg_o, pos_o}, 32'h0000_00AA);
      for (int i = 0; i < 6; i++) wr(a[i], 8'h00);
   endtask

   task automatic t_clocks;
      logic [7:0] p[4] = '{8'h1F, 8'h1F, 8'h00, 8'h1E};
      logic [7:0] f[4] = '{8'h20, 8'h00, 8'h20, 8'h00};
      int g[4] = '{12, 30, 24, 1860};
      wr(ADDR_CCTRL, 8'h04);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_PRESC, p[i]);
         wr(ADDR_FRATE, f[i]);
         wait_ev(1'b0, 3);
         chk("mod_tick_gap", tick_gap, g[i]);
      end
   endtask

   task automatic t_rate;
      logic [31:0] q;
      int code, ord, frame;
      wr(ADDR_PRESC, 8'h1F);
      for (int i = 0; i < 11; i++) begin
         code = (i < 9) ? i : ((i == 9) ? 6 : 8);
         ord = (i >= 9) ? 1 : 0;
         frame = (1 << (OSR_LOG2 - code)) * (ord + 1);
         wr(ADDR_FRATE, {ord[0], 1'b0, 2'b10, code[3:0]});
         wr(ADDR_CCTRL, 8'h04);
         wait_ev(1'b1, 3);
         chk("word_gap", irq_gap, 12 * frame);
         rd_res(q);
         chk("result", q, frame);
         rd(ADDR_CCTRL, q);
         chk("eoc_set", q, 32'h0000_0014);
      end
   endtask

   task automatic t_hold;
      logic [31:0] q;
      int c;
      wr(ADDR_FRATE, 8'h26);
      wait_ev(1'b1, 2);
      // The second write clears the end flag once no result can race it.
      wr(ADDR_CCTRL, 8'h24);
      wr(ADDR_CCTRL, 8'h24);
      repeat (2) @(posedge clk_sys_in);
      c = irq_cnt;
      mod_bit <= 1'b0;
      repeat (300) @(posedge clk_sys_in);
      chk("hold_no_irq", irq_cnt, c);
      rd(ADDR_CCTRL, q);
      chk("hold_eoc", q, 32'h0000_0024);
      wr(ADDR_RES_LO, 8'hFF);
      rd_res(q);
      chk("hold_result", q, 32'h0000_0004);
      wr(ADDR_CCTRL, 8'h04);
      wait_ev(1'b1, 2);
      rd_res(q);
      chk("release_result", q, 32'h00FF_FFFC);
      rd(ADDR_CCTRL, q);
      chk("release_eoc", q, 32'h0000_0014);
   endtask

   task automatic t_srst;
      logic [31:0] q;
      int c;
      // Freeze right after a word so that no pulse is caught standing.
      wait_ev(1'b1, 1);
      c = tick_cnt + irq_cnt;
      ce <= 1'b0;
      repeat (100) @(posedge clk_sys_in);
      chk("ce_freeze", tick_cnt + irq_cnt, c);
      ce <= 1'b1;
      wr(ADDR_CCTRL, 8'h0C);
      wr(ADDR_CCTRL, 8'h0C);
      mod_bit <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      c = irq_cnt;
      repeat (300) @(posedge clk_sys_in);
      chk("srst_no_irq", irq_cnt, c);
      chk("srst_out", srst_o, 32'h0000_0001);
      rd(ADDR_CCTRL, q);
      chk("eoc_cleared", q, 32'h0000_000C);
      wr(ADDR_CCTRL, 8'h04);
      wait_ev(1'b1, 1);
      // The first word after the release counts only fresh ones.
      rd_res(q);
      chk("restart_result", q, 32'h0000_0004);
      wr(ADDR_CCTRL, 8'h00);
      repeat (2) @(posedge clk_sys_in);
      c = irq_cnt;
      repeat (300) @(posedge clk_sys_in);
      chk("off_no_irq", irq_cnt, c);
      chk("off_out", on_o, 32'h0000_0000);
   endtask

   task final_report;
      if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge clk_sys_in);
      error_cnt++;
      final_report();
   end

   initial begin
      repeat (8) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      t_regs();
      t_clocks();
      t_rate();
      t_hold();
      t_srst();
      final_report();
   end
endmodule
`default_nettype wire
